// ---- inc/lrr_pkg.sv ----
// How it works
// - no freq arming while breaker closed
// - freq trip then open arms, outputs on
// - control mode: control flag, lamp off
// - inhibit hides outputs while held
// - abandon timeout drops outputs
// - nominal frequency clears trip, not arming
// - quick freq return still shows pending
// - reset command clears indications, outputs
// - close pulse after delay from voltage
// - stage two trip arms like stage one
// - freq close needs phase A floor
// - freq close needs frequency floor
// - zero delay closes at once
// - one-phase check: any phase suffices
// - wye two-phase: two of three
// - wye three-phase: all three
// - delta: two and three need both
// - voltage restoration mirrors frequency one
package lrr_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned TICK_MS     = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TMR_W       = 16;
    localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;

    // ==========================================================
    // settings
    typedef enum logic [1:0] {
        LRR_PH_ONE,
        LRR_PH_TWO,
        LRR_PH_THREE
    } lrr_phases_e;

    typedef struct packed {
        logic [TMR_W-1:0] delay_ticks;
        logic [TMR_W-1:0] abandon_ticks;
        logic             control_mode;
        logic             enable;
    } lrr_cfg_s;

    typedef struct packed {
        logic pending_alarm;
        logic pending_control;
        logic alarm_lamp;
        logic assigned_out;
    } lrr_ind_s;

    typedef enum logic [1:0] {
        LRR_IDLE,
        LRR_TRIPPED,
        LRR_ARMED
    } lrr_state_e;

    typedef struct packed {
        lrr_state_e       st;
        logic             shown;
        logic             volt_seen;
        logic [TMR_W-1:0] dly;
        logic [TMR_W-1:0] abandon;
    } lrr_ch_s;
endpackage

// ---- logic/lrr_reclose.sv ----
`timescale 1ns/1ps
module lrr_reclose (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            sys_rst,
    // pins from outside
    input  wire logic            brk_open_pin,
    input  wire logic            inhibit_pin,
    input  wire logic            reset_cmd_pin,
    // trip and comparator results
    input  wire logic            uf1_trip,
    input  wire logic            uf2_trip,
    input  wire logic            uf2_trip_en,
    input  wire logic            freq_nominal,
    input  wire logic            freq_above_floor,
    input  wire logic            va_above_freq_vfloor,
    input  wire logic            uv_trip,
    input  wire logic            volt_nominal,
    input  wire logic [2:0]      v_above_floor,
    // configuration
    input  wire lrr_pkg::lrr_cfg_s    freq_cfg,
    input  wire lrr_pkg::lrr_cfg_s    volt_cfg,
    input  wire lrr_pkg::lrr_phases_e volt_phases,
    input  wire logic                 wiring_delta,
    // indications and close
    output lrr_pkg::lrr_ind_s    freq_ind,
    output lrr_pkg::lrr_ind_s    volt_ind,
    output logic                 close_pulse
);
    import lrr_pkg::*;

    typedef struct packed {
        logic [1:0]                   s_open;
        logic [1:0]                   s_inh;
        logic [1:0]                   s_rst;
        logic [$clog2(TICK_CYCLES):0] div;
        logic                         tick;
        lrr_ch_s                      f;
        lrr_ch_s                      v;
        lrr_ind_s                     fi;
        lrr_ind_s                     vi;
        logic                         close;
    } lrr_all_s;

    lrr_all_s st_reg;
    lrr_all_s st_next;

    // ==========================================================
    // phase check
    function automatic logic volt_ok(input logic [2:0] v,
                                     input lrr_phases_e ph,
                                     input logic delta);
        logic [1:0] cnt;
        cnt = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
        if (ph == LRR_PH_ONE)
            volt_ok = |v;
        else if (delta)
            volt_ok = v[0] & v[2];
        else if (ph == LRR_PH_TWO)
            volt_ok = cnt >= 2'd2;
        else
            volt_ok = &v;
    endfunction

    // ==========================================================
    // one restoration channel step
    function automatic lrr_ch_s step(input lrr_ch_s c,
                                     input lrr_cfg_s cfg,
                                     input logic trip,
                                     input logic nominal,
                                     input logic permit,
                                     input logic volt_now,
                                     input logic brk_open,
                                     input logic rst_cmd,
                                     input logic tick,
                                     output logic fire);
        lrr_ch_s n;
        n = c;
        fire = 1'b0;
        case (c.st)
            LRR_IDLE: begin
                if (trip && cfg.enable) begin
                    n.st = LRR_TRIPPED;
                    if (brk_open) begin
                        n.st = LRR_ARMED;
                        n.shown = 1'b1;
                        n.volt_seen = 1'b0;
                        n.abandon = cfg.abandon_ticks;
                    end
                end
            end
            LRR_TRIPPED: begin
                if (!cfg.enable) begin
                    n.st = LRR_IDLE;
                end else if (brk_open) begin
                    n.st = LRR_ARMED;
                    n.shown = 1'b1;
                    n.volt_seen = 1'b0;
                    n.abandon = cfg.abandon_ticks;
                end else if (nominal) begin
                    n.st = LRR_IDLE;
                end
            end
            LRR_ARMED: begin
                if (!volt_now)
                    n.volt_seen = 1'b0;
                else if (!c.volt_seen) begin
                    n.volt_seen = 1'b1;
                    n.dly = cfg.delay_ticks;
                end else if (tick && c.dly != '0)
                    n.dly = c.dly - 1'b1;
                if (tick && c.shown) begin
                    if (c.abandon[TMR_W-1:1] == '0) begin
                        n.shown = 1'b0;
                        n.abandon = '0;
                    end else
                        n.abandon = c.abandon - 1'b1;
                end
                if (c.volt_seen && volt_now && permit && c.dly == '0) begin
                    fire = 1'b1;
                    n.st = LRR_IDLE;
                    n.shown = 1'b0;
                end
                if (!cfg.enable) begin
                    n.st = LRR_IDLE;
                    n.shown = 1'b0;
                end
            end
            default: n.st = LRR_IDLE;
        endcase
        if (rst_cmd) begin
            n.shown = 1'b0;
            if (n.st == LRR_ARMED)
                n.st = LRR_IDLE;
        end
        if (n.st == LRR_IDLE) begin
            n.shown = 1'b0;
            n.volt_seen = 1'b0;
        end
        step = n;
    endfunction

    function automatic lrr_ind_s show(input logic on, input lrr_cfg_s c);
        lrr_ind_s r;
        r.pending_alarm   = on & ~c.control_mode;
        r.pending_control = on & c.control_mode;
        r.alarm_lamp      = on & ~c.control_mode;
        r.assigned_out    = on;
        show = r;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic f_fire;
        logic v_fire;
        logic f_trip;
        logic f_permit;
        logic v_permit;
        f_fire = 1'b0;
        v_fire = 1'b0;
        f_trip = 1'b0;
        f_permit = 1'b0;
        v_permit = 1'b0;
        st_next = st_reg;
        st_next.s_open = {st_reg.s_open[0], brk_open_pin};
        st_next.s_inh  = {st_reg.s_inh[0], inhibit_pin};
        st_next.s_rst  = {st_reg.s_rst[0], reset_cmd_pin};
        st_next.tick = 1'b0;
        if (st_reg.div == ($bits(st_reg.div))'(TICK_CYCLES - 1)) begin
            st_next.div = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 1'b1;
        end
        f_trip = uf1_trip | (uf2_trip & uf2_trip_en);
        f_permit = va_above_freq_vfloor & freq_above_floor;
        v_permit = volt_ok(v_above_floor, volt_phases, wiring_delta);
        st_next.f = step(st_reg.f, freq_cfg, f_trip, freq_nominal, f_permit,
                         va_above_freq_vfloor, st_reg.s_open[1],
                         st_reg.s_rst[1], st_reg.tick, f_fire);
        st_next.v = step(st_reg.v, volt_cfg, uv_trip, volt_nominal, v_permit,
                         |v_above_floor, st_reg.s_open[1],
                         st_reg.s_rst[1], st_reg.tick, v_fire);
        st_next.fi = show(st_next.f.shown & ~st_reg.s_inh[1], freq_cfg);
        st_next.vi = show(st_next.v.shown & ~st_reg.s_inh[1], volt_cfg);
        st_next.close = f_fire | v_fire;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.f.st <= LRR_IDLE;
            st_reg.v.st <= LRR_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign freq_ind    = st_reg.fi;
    assign volt_ind    = st_reg.vi;
    assign close_pulse = st_reg.close;
endmodule // lrr_reclose

// ---- testbench/lrr_breaker_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// breaker: opens on request, closes on the close pulse
module lrr_breaker_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // commands
    input  wire logic open_req,
    input  wire logic close_pulse,
    // status
    output logic      brk_open_pin
);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) brk_open_pin <= 1'b0;
        else if (open_req) brk_open_pin <= 1'b1;
        else if (close_pulse) brk_open_pin <= 1'b0;
    end
endmodule // lrr_breaker_model

// ---- testbench/lrr_monitor.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checks
module lrr_monitor
    import lrr_pkg::*;
(
    input wire logic              ref_clk, sys_rst, brk_open_pin,
    input wire logic              inhibit_pin, reset_cmd_pin, close_pulse,
    input wire lrr_pkg::lrr_cfg_s freq_cfg,
    input wire lrr_pkg::lrr_ind_s freq_ind, volt_ind
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_arm_needs_open: assert property (
        $rose(freq_ind.assigned_out) |-> brk_open_pin)
        else $error("indication rose with breaker closed");
    a_lamp_follows: assert property (
        freq_ind.alarm_lamp == freq_ind.pending_alarm &&
        volt_ind.alarm_lamp == volt_ind.pending_alarm)
        else $error("lamp differs from alarm indication");
    a_ctrl_no_lamp: assert property (
        freq_cfg.control_mode [*2] |-> !freq_ind.alarm_lamp)
        else $error("lamp lit in control mode");
    a_mode_excl: assert property (
        !(freq_ind.pending_alarm && freq_ind.pending_control))
        else $error("alarm and control both shown");
    a_inhibit_mask: assert property (
        inhibit_pin [*4] |=> freq_ind == '0 && volt_ind == '0)
        else $error("indication shown while inhibited");
    a_reset_cmd: assert property (
        reset_cmd_pin [*4] |=> freq_ind == '0 && volt_ind == '0)
        else $error("indication kept after reset command");
    a_one_pulse: assert property (close_pulse |=> !close_pulse)
        else $error("close pulse longer than one cycle");
    a_close_open: assert property (close_pulse |-> brk_open_pin)
        else $error("close pulse with breaker closed");
    cover property (close_pulse);
    cover property ($rose(freq_ind.pending_control));
    cover property ($rose(volt_ind.assigned_out));
endmodule // lrr_monitor
bind lrr_reclose lrr_monitor mon (.ref_clk, .sys_rst, .brk_open_pin,
    .inhibit_pin, .reset_cmd_pin, .close_pulse, .freq_cfg, .freq_ind,
    .volt_ind);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
// ==========================================================
// stimulus and checks
module testbench;
    import lrr_pkg::*;
    logic        ref_clk = 0, sys_rst = 1, open_req = 0, brk_open_pin;
    logic        inhibit_pin = 0, reset_cmd_pin = 0, uf1_trip = 0;
    logic        uf2_trip = 0, uf2_trip_en = 0, freq_nominal = 0;
    logic        freq_above_floor = 0, va_above_freq_vfloor = 0;
    logic        uv_trip = 0, volt_nominal = 0, wiring_delta = 0;
    logic [2:0]  v_above_floor = 3'h0;
    lrr_phases_e volt_phases = LRR_PH_ONE;
    lrr_cfg_s    freq_cfg = {16'h0000, 16'hFFFF, 1'b0, 1'b1};
    lrr_cfg_s    volt_cfg = {16'h0000, 16'hFFFF, 1'b0, 1'b1};
    lrr_ind_s    freq_ind, volt_ind;
    logic        close_pulse;
    logic [3:0]  closes = 4'h0;
    int          failures = 0, check_count = 0;
    // {phases, delta, v_above_floor, close expected}
    logic [6:0]  rows [12] = '{7'h03, 7'h09, 7'h27, 7'h28, 7'h2B, 7'h4C,
                               7'h4F, 7'h19, 7'h32, 7'h3B, 7'h58, 7'h5B};
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (sys_rst) closes <= 4'h0;
        else if (close_pulse) closes <= closes + 4'h1;
    end
    lrr_reclose dut (.ref_clk, .sys_rst, .brk_open_pin, .inhibit_pin,
        .reset_cmd_pin, .uf1_trip, .uf2_trip, .uf2_trip_en, .freq_nominal,
        .freq_above_floor, .va_above_freq_vfloor, .uv_trip, .volt_nominal,
        .v_above_floor, .freq_cfg, .volt_cfg, .volt_phases, .wiring_delta,
        .freq_ind, .volt_ind, .close_pulse);
    lrr_breaker_model brk (.ref_clk, .sys_rst, .open_req, .close_pulse,
        .brk_open_pin);
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic restart;
        sys_rst <= 1;
        v_above_floor <= 3'h0;
        w(3);
        sys_rst <= 0;
        w(1);
    endtask
    task automatic open_brk;
        open_req <= 1;
        w(1);
        open_req <= 0;
    endtask
    initial begin
        #2_000_000;
        failures++;
        summarize;
    end
    initial begin
        foreach (rows[i]) begin
            restart;
            volt_phases <= lrr_phases_e'(rows[i][6:5]);
            wiring_delta <= rows[i][4];
            uv_trip <= 1;
            open_brk;
            w(6);
            uv_trip <= 0;
            v_above_floor <= rows[i][3:1];
            w(8);
            chk(closes, {3'h0, rows[i][0]});
        end
        restart;
        uf1_trip <= 1;
        w(8);
        chk(freq_ind, 4'h0);
        uf1_trip <= 0;
        freq_nominal <= 1;
        w(2);
        freq_nominal <= 0;
        open_brk;
        w(6);
        chk(freq_ind, 4'h0);
        uf1_trip <= 1;
        w(6);
        chk(freq_ind, 4'hB);
        freq_cfg.control_mode <= 1;
        w(3);
        chk(freq_ind, 4'h5);
        freq_cfg.control_mode <= 0;
        inhibit_pin <= 1;
        w(6);
        chk(freq_ind, 4'h0);
        inhibit_pin <= 0;
        w(6);
        chk(freq_ind, 4'hB);
        uf1_trip <= 0;
        reset_cmd_pin <= 1;
        w(6);
        chk(freq_ind, 4'h0);
        reset_cmd_pin <= 0;
        restart;
        uf2_trip_en <= 1;
        uf2_trip <= 1;
        open_brk;
        w(6);
        uf2_trip <= 0;
        chk(freq_ind, 4'hB);
        freq_above_floor <= 1;
        w(6);
        chk(closes, 4'h0);
        freq_above_floor <= 0;
        va_above_freq_vfloor <= 1;
        w(6);
        chk(closes, 4'h0);
        freq_above_floor <= 1;
        w(6);
        chk(closes, 4'h1);
        chk(freq_ind, 4'h0);
        freq_above_floor <= 0;
        va_above_freq_vfloor <= 0;
        restart;
        open_brk;
        w(4);
        uf1_trip <= 1;
        w(1);
        uf1_trip <= 0;
        freq_nominal <= 1;
        w(6);
        chk(freq_ind, 4'hB);
        freq_nominal <= 0;
        restart;
        volt_cfg.abandon_ticks <= 16'h0001;
        uv_trip <= 1;
        open_brk;
        w(6);
        uv_trip <= 0;
        chk(volt_ind, 4'hB);
        w(TICK_CYCLES + 100);
        chk(volt_ind, 4'h0);
        summarize;
    end
endmodule // testbench
